// File: include/lipwm_consts.svh
`ifndef LIPWM_CONSTS_SVH
`define LIPWM_CONSTS_SVH

// register address codes
`define LIPWM_ADDR_MASTER_OUT8 8'h0E
`define LIPWM_ADDR_OUT1_OUT0 8'h10

// nibble field positions
`define LIPWM_HI_MSB 7
`define LIPWM_HI_LSB 4
`define LIPWM_LO_MSB 3
`define LIPWM_LO_LSB 0

// reset values and the unmapped read value
`define LIPWM_RST_MASTER_OUT8 8'h00
`define LIPWM_RST_OUT1_OUT0 8'h00
`define LIPWM_RST_RDATA 8'h00
`define LIPWM_UNMAPPED_RDATA 8'h00

// special field codes
`define LIPWM_MASTER_OFF 4'h0
`define LIPWM_LEVEL_STATIC 4'hF

// timing counts: 16 fine steps per slot, 15 coarse slots per period
`define LIPWM_FINE_LAST 4'hF
`define LIPWM_COARSE_LAST 4'hE
`define LIPWM_CNT_ZERO 4'h0
`define LIPWM_CNT_ONE 4'h1

`endif

// File: include/lipwm_pkg.sv
package lipwm_pkg;

    // one register access: address code and write data
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } lipwm_req_t;

    // internal oscillator state
    typedef enum logic [1:0] {
        LIPWM_OSC_STOP = 2'b01,
        LIPWM_OSC_RUN = 2'b10
    } lipwm_osc_t;

endpackage

// File: core/lipwm_cell.sv
`include "lipwm_consts.svh"

// one output's waveform: fine duty nested inside the active coarse slots
module lipwm_cell (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] level_i,
    input wire logic osc_run_i,
    input wire logic coarse_on_i,
    input wire logic [3:0] fine_i,
    output logic sink_o
);

    logic sink_r;
    logic sink_nxt;

    // sink means the output pulls low, which lights the led
    always_comb begin
        sink_nxt = 1'b0;
        if (!osc_run_i) begin
            sink_nxt = 1'b0;
        end else if (level_i == `LIPWM_LEVEL_STATIC) begin
            sink_nxt = 1'b1;
        end else begin
            // fine <= k covers k+1 of 16 steps, only in active slots
            sink_nxt = coarse_on_i && (fine_i <= level_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sink_r <= 1'b0;
        end else begin
            sink_r <= sink_nxt;
        end
    end

    assign sink_o = sink_r;

    property p_fine_on;
        @(posedge clk_i) disable iff (!rst_n_i)
        (osc_run_i && coarse_on_i && level_i != `LIPWM_LEVEL_STATIC
            && fine_i <= level_i) |=> sink_r;
    endproperty
    a_fine_on: assert property (p_fine_on)
        else $error("output not sinking inside its fine duty");

    property p_fine_off;
        @(posedge clk_i) disable iff (!rst_n_i)
        (osc_run_i && level_i != `LIPWM_LEVEL_STATIC
            && fine_i > level_i) |=> !sink_r;
    endproperty
    a_fine_off: assert property (p_fine_off)
        else $error("output sinking past its fine duty");

    property p_static;
        @(posedge clk_i) disable iff (!rst_n_i)
        (osc_run_i && level_i == `LIPWM_LEVEL_STATIC) |=> sink_r;
    endproperty
    a_static: assert property (p_static)
        else $error("static level code did not hold output low");

    property p_nested;
        @(posedge clk_i) disable iff (!rst_n_i)
        (osc_run_i && !coarse_on_i && level_i != `LIPWM_LEVEL_STATIC)
            |=> !sink_r;
    endproperty
    a_nested: assert property (p_nested)
        else $error("output sinking outside the master duty");

endmodule

// File: core/lipwm_top.sv
// Overview of operation
// - register 0x0E holds master level high nibble, output eight level low.
// - master level zero stops the oscillator; all outputs released, no pwm.
// - nonzero master level n gives a global duty of n fifteenths.
// - output eight level k below 1111 gives duty of k+1 sixteenths.
// - output eight level 1111 holds a static level without pwm.
// - register 0x10 holds output one level high, output zero level low.
// - each output level k below 1111 gives duty of k+1 sixteenths.
// - an output level 1111 holds that output static, bypassing pwm.
// - reading either intensity register returns the last written fields.
// - the active part of each period drives the output low.
`include "lipwm_consts.svh"

module lipwm_top #(
    parameter int NUM_OUT = 3
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire lipwm_pkg::lipwm_req_t reg_req_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic led_out_zero_o,
    output logic led_out_zero_oe_n_o,
    output logic led_out_one_o,
    output logic led_out_one_oe_n_o,
    output logic led_out_eight_o,
    output logic led_out_eight_oe_n_o
);

    logic [7:0] master_and_out8_intensity_r;
    logic [7:0] master_and_out8_intensity_nxt;
    logic [7:0] out1_out0_intensity_r;
    logic [7:0] out1_out0_intensity_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    lipwm_pkg::lipwm_osc_t osc_r;
    lipwm_pkg::lipwm_osc_t osc_nxt;
    logic [3:0] fine_r;
    logic [3:0] fine_nxt;
    logic [3:0] coarse_r;
    logic [3:0] coarse_nxt;
    logic [3:0] master_level;
    logic coarse_on;
    logic osc_run;
    logic [3:0] level [NUM_OUT];
    logic [NUM_OUT-1:0] sink;

    assign master_level =
        master_and_out8_intensity_r[`LIPWM_HI_MSB:`LIPWM_HI_LSB];

    // register writes: a strobe with a matching code replaces the byte
    always_comb begin
        master_and_out8_intensity_nxt = master_and_out8_intensity_r;
        out1_out0_intensity_nxt = out1_out0_intensity_r;
        if (reg_wr_i) begin
            if (reg_req_i.addr == `LIPWM_ADDR_MASTER_OUT8) begin
                master_and_out8_intensity_nxt = reg_req_i.data;
            end else if (reg_req_i.addr == `LIPWM_ADDR_OUT1_OUT0) begin
                out1_out0_intensity_nxt = reg_req_i.data;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            master_and_out8_intensity_r <= `LIPWM_RST_MASTER_OUT8;
            out1_out0_intensity_r <= `LIPWM_RST_OUT1_OUT0;
        end else begin
            master_and_out8_intensity_r <= master_and_out8_intensity_nxt;
            out1_out0_intensity_r <= out1_out0_intensity_nxt;
        end
    end

    // read-back: answer one cycle after the strobe; unknown codes read zero
    always_comb begin
        rdata_nxt = rdata_r;
        rvalid_nxt = reg_rd_i;
        if (reg_rd_i) begin
            if (reg_req_i.addr == `LIPWM_ADDR_MASTER_OUT8) begin
                rdata_nxt = master_and_out8_intensity_r;
            end else if (reg_req_i.addr == `LIPWM_ADDR_OUT1_OUT0) begin
                rdata_nxt = out1_out0_intensity_r;
            end else begin
                rdata_nxt = `LIPWM_UNMAPPED_RDATA;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_r <= `LIPWM_RST_RDATA;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;
    assign reg_rvalid_o = rvalid_r;

    // oscillator: 16 fine steps per coarse slot, 15 slots per period;
    // a stop parks the counters so a restart begins a fresh period
    always_comb begin
        osc_nxt = osc_r;
        fine_nxt = fine_r;
        coarse_nxt = coarse_r;
        case (osc_r)
            lipwm_pkg::LIPWM_OSC_STOP: begin
                fine_nxt = `LIPWM_CNT_ZERO;
                coarse_nxt = `LIPWM_CNT_ZERO;
                if (master_level != `LIPWM_MASTER_OFF) begin
                    osc_nxt = lipwm_pkg::LIPWM_OSC_RUN;
                end
            end
            lipwm_pkg::LIPWM_OSC_RUN: begin
                if (master_level == `LIPWM_MASTER_OFF) begin
                    osc_nxt = lipwm_pkg::LIPWM_OSC_STOP;
                    fine_nxt = `LIPWM_CNT_ZERO;
                    coarse_nxt = `LIPWM_CNT_ZERO;
                end else begin
                    fine_nxt = fine_r + `LIPWM_CNT_ONE;
                    if (fine_r == `LIPWM_FINE_LAST) begin
                        if (coarse_r == `LIPWM_COARSE_LAST) begin
                            coarse_nxt = `LIPWM_CNT_ZERO;
                        end else begin
                            coarse_nxt = coarse_r + `LIPWM_CNT_ONE;
                        end
                    end
                end
            end
            default: begin
                osc_nxt = lipwm_pkg::LIPWM_OSC_STOP;
                fine_nxt = `LIPWM_CNT_ZERO;
                coarse_nxt = `LIPWM_CNT_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            osc_r <= lipwm_pkg::LIPWM_OSC_STOP;
            fine_r <= `LIPWM_CNT_ZERO;
            coarse_r <= `LIPWM_CNT_ZERO;
        end else begin
            osc_r <= osc_nxt;
            fine_r <= fine_nxt;
            coarse_r <= coarse_nxt;
        end
    end

    // the first n of 15 slots are active, giving n fifteenths
    assign osc_run = (osc_r == lipwm_pkg::LIPWM_OSC_RUN)
        && (master_level != `LIPWM_MASTER_OFF);
    assign coarse_on = coarse_r < master_level;

    // level map: index 0 and 1 from 0x10, index 2 is output eight
    assign level[0] = out1_out0_intensity_r[`LIPWM_LO_MSB:`LIPWM_LO_LSB];
    assign level[1] = out1_out0_intensity_r[`LIPWM_HI_MSB:`LIPWM_HI_LSB];
    assign level[2] =
        master_and_out8_intensity_r[`LIPWM_LO_MSB:`LIPWM_LO_LSB];

    // one waveform cell per output
    for (genvar i = 0; i < NUM_OUT; i++) begin : g_cell
        lipwm_cell u_cell (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .level_i(level[i]),
            .osc_run_i(osc_run),
            .coarse_on_i(coarse_on),
            .fine_i(fine_r),
            .sink_o(sink[i])
        );
    end

    // open drain: pin level is always low, enable low while sinking
    assign led_out_zero_o = 1'b0;
    assign led_out_one_o = 1'b0;
    assign led_out_eight_o = 1'b0;
    assign led_out_zero_oe_n_o = !sink[0];
    assign led_out_one_oe_n_o = !sink[1];
    assign led_out_eight_oe_n_o = !sink[2];

    property p_wr_master;
        @(posedge clk_i) disable iff (!rst_n_i)
        (reg_wr_i && reg_req_i.addr == `LIPWM_ADDR_MASTER_OUT8)
            |=> (master_and_out8_intensity_r == $past(reg_req_i.data));
    endproperty
    a_wr_master: assert property (p_wr_master)
        else $error("master and output eight byte not stored");

    property p_wr_out10;
        @(posedge clk_i) disable iff (!rst_n_i)
        (reg_wr_i && reg_req_i.addr == `LIPWM_ADDR_OUT1_OUT0)
            |=> (out1_out0_intensity_r == $past(reg_req_i.data));
    endproperty
    a_wr_out10: assert property (p_wr_out10)
        else $error("output one and zero byte not stored");

    property p_readback;
        @(posedge clk_i) disable iff (!rst_n_i)
        (reg_wr_i && reg_req_i.addr == `LIPWM_ADDR_OUT1_OUT0)
            ##1 (reg_rd_i && !reg_wr_i
            && reg_req_i.addr == `LIPWM_ADDR_OUT1_OUT0)
            |=> (reg_rvalid_o && reg_rdata_o == $past(reg_req_i.data, 2));
    endproperty
    a_readback: assert property (p_readback)
        else $error("read-back differs from last write");

    property p_stop;
        @(posedge clk_i) disable iff (!rst_n_i)
        (master_level == `LIPWM_MASTER_OFF) [*3] |->
            (osc_r == lipwm_pkg::LIPWM_OSC_STOP && fine_r == 4'h0
            && led_out_zero_oe_n_o && led_out_one_oe_n_o
            && led_out_eight_oe_n_o);
    endproperty
    a_stop: assert property (p_stop)
        else $error("oscillator or outputs active with master off");

    property p_wrap;
        @(posedge clk_i) disable iff (!rst_n_i)
        (osc_run && fine_r == `LIPWM_FINE_LAST
            && coarse_r == `LIPWM_COARSE_LAST && $stable(master_level))
            |=> (coarse_r == 4'h0 && fine_r == 4'h0);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("period is not fifteen coarse slots");

    // a write landing in the next step may legally stretch the pulse
    property p_low_active;
        @(posedge clk_i) disable iff (!rst_n_i)
        (osc_run && coarse_r == 4'h0 && level[2] == 4'h0
            && fine_r == 4'h0 && !reg_wr_i) |=> !led_out_eight_oe_n_o ##1
            led_out_eight_oe_n_o;
    endproperty
    a_low_active: assert property (p_low_active)
        else $error("active step did not pull output eight low");

endmodule

// File: testbench/lipwm_led_load.sv
// led and pull-up on each open-drain output, as seen from the board
module lipwm_led_load (
    input wire logic [2:0] oe_n_i,
    input wire logic [2:0] pin_i,
    output logic [2:0] pad_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // released pins float up to the pull-up, so a stale low never shows
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pad_o[i] = oe_n_i[i] ? 1'b1 : pin_i[i];
        end
    end
endmodule

// File: testbench/testbench.sv
`include "lipwm_consts.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    lipwm_pkg::lipwm_req_t reg_req_i = '0;
    logic [7:0] reg_rdata_o;
    logic reg_rvalid_o;
    logic [2:0] pin;
    logic [2:0] oe_n;
    logic [2:0] pad;
    int n_mismatch = 0;
    int samples_checked = 0;

    // 250 MHz
    always #2 clk_i = ~clk_i;

    lipwm_top #(.NUM_OUT(3)) dut_u (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_req_i(reg_req_i),
        .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o),
        .led_out_zero_o(pin[0]),
        .led_out_zero_oe_n_o(oe_n[0]),
        .led_out_one_o(pin[1]),
        .led_out_one_oe_n_o(oe_n[1]),
        .led_out_eight_o(pin[2]),
        .led_out_eight_oe_n_o(oe_n[2])
    );

    lipwm_led_load load_u (
        .oe_n_i(oe_n),
        .pin_i(pin),
        .pad_o(pad)
    );

    task automatic conclude();
        $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t byte %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        samples_checked++;
        if (got != exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t low count %0d want %0d",
                $time, got, exp);
        end
    endtask

    // one-cycle write strobe, dropped after the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        reg_wr_i = 1'b1;
        reg_req_i = '{addr: a, data: d};
        @(posedge clk_i);
        #1;
        reg_wr_i = 1'b0;
    endtask

    // answer lands one cycle after the strobe edge and stands one cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        #1;
        reg_rd_i = 1'b1;
        reg_req_i = '{addr: a, data: 8'h00};
        @(posedge clk_i);
        #1;
        reg_rd_i = 1'b0;
        chk_byte({7'h00, reg_rvalid_o}, 8'h01);
        chk_byte(reg_rdata_o, exp);
        @(posedge clk_i);
        #1;
        chk_byte({7'h00, reg_rvalid_o}, 8'h00);
    endtask

    // write, then read the same code on the very next edge
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        reg_wr_i = 1'b1;
        reg_req_i = '{addr: a, data: d};
        @(posedge clk_i);
        #1;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b1;
        reg_req_i = '{addr: a, data: 8'h00};
        @(posedge clk_i);
        #1;
        reg_rd_i = 1'b0;
        chk_byte({7'h00, reg_rvalid_o}, 8'h01);
        chk_byte(reg_rdata_o, d);
    endtask

    // sunk cycles in one 240-clock period: product of both fractions, or all 240 for level 1111 with a nonzero master
    function automatic int expect_low(input logic [3:0] m,
                                      input logic [3:0] k);
        if (m == 4'h0)
            return 0;
        if (k == 4'hF)
            return 240;
        return int'(m) * (int'(k) + 1);
    endfunction

    // set levels, let them settle, then count lit cycles over one period
    task automatic run_case(input logic [3:0] m, input logic [3:0] k8,
                            input logic [3:0] k1, input logic [3:0] k0);
        int cnt [3];
        cnt = '{0, 0, 0};
        wr(`LIPWM_ADDR_MASTER_OUT8, {m, k8});
        wr(`LIPWM_ADDR_OUT1_OUT0, {k1, k0});
        repeat (20) @(posedge clk_i);
        repeat (240) begin
            @(posedge clk_i);
            #1;
            for (int i = 0; i < 3; i++)
                if (pad[i] === 1'b0) cnt[i]++;
        end
        chk_cnt(cnt[2], expect_low(m, k8));
        chk_cnt(cnt[1], expect_low(m, k1));
        chk_cnt(cnt[0], expect_low(m, k0));
    endtask

    // main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        rd(`LIPWM_ADDR_MASTER_OUT8, 8'h00);
        rd(`LIPWM_ADDR_OUT1_OUT0, 8'h00);
        wr(`LIPWM_ADDR_OUT1_OUT0, 8'h5A);
        rd(`LIPWM_ADDR_OUT1_OUT0, 8'h5A);
        wr(`LIPWM_ADDR_MASTER_OUT8, 8'hC3);
        rd(`LIPWM_ADDR_MASTER_OUT8, 8'hC3);
        // unmapped code: write dropped, read gives zero
        wr(8'h11, 8'hFF);
        rd(8'h11, 8'h00);
        rd(`LIPWM_ADDR_MASTER_OUT8, 8'hC3);
        rd(`LIPWM_ADDR_OUT1_OUT0, 8'h5A);
        wr_rd(`LIPWM_ADDR_OUT1_OUT0, 8'hA5);
        wr_rd(`LIPWM_ADDR_MASTER_OUT8, 8'h3C);
        run_case(4'hF, 4'h0, 4'hF, 4'hE);
        run_case(4'h1, 4'hE, 4'h0, 4'h7);
        run_case(4'h7, 4'hF, 4'h3, 4'h0);
        run_case(4'hD, 4'h6, 4'hF, 4'hF);
        run_case(4'h0, 4'hF, 4'h5, 4'hF);
        run_case(4'h2, 4'h9, 4'hE, 4'h1);
        // reset again while running: every output released, bytes cleared
        rst_n_i = 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        chk_byte({5'h00, pad}, 8'h07);
        rd(`LIPWM_ADDR_MASTER_OUT8, 8'h00);
        rd(`LIPWM_ADDR_OUT1_OUT0, 8'h00);
        conclude();
    end

    // watchdog: the sequence needs about 1650 cycles
    initial begin
        #40000;
        n_mismatch++;
        conclude();
    end
endmodule
